/* rtl/pmtr_mem.sv */
// program memory array with one synchronous read port and a load port
`timescale 1ns/10ps
module pmtr_mem
   import pmtr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] rd_addr,
   output logic [pmtr_pkg::PMTR_WORD_W-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] wr_addr,
   input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] wr_data
);
   logic [PMTR_WORD_W-1:0] mem [0:PMTR_DEPTH-1];

   // write path stands in for the programming engine
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read, one cycle of latency
   always_ff @(posedge sys_clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

/* rtl/pmtr_pkg.sv */
// shared constants for the program memory table read port
package pmtr_pkg;
   localparam int PMTR_ADDR_W = 14;
   localparam int PMTR_DEPTH = 16384;
   localparam int PMTR_WORD_W = 16;
   localparam int PMTR_BYTE_W = 8;
   localparam int PMTR_DADDR_W = 8;
   localparam int PMTR_SECT_W = 2;
   localparam logic [PMTR_ADDR_W-1:0] PMTR_RESET_VEC = 14'h0000;
   localparam logic [PMTR_SECT_W-1:0] PMTR_SECTOR0 = 2'h0;
   localparam logic [PMTR_BYTE_W-1:0] PMTR_LATCH_RST = 8'h00;
   localparam logic [PMTR_WORD_W-1:0] PMTR_WORD_RST = 16'h0000;
   localparam logic [PMTR_ADDR_W-1:0] PMTR_PC_STEP = 14'h0001;
   typedef enum logic [1:0] {
      PMTR_ST_FETCH = 2'b00,
      PMTR_ST_TABLE = 2'b01,
      PMTR_ST_FLUSH = 2'b10
   } pmtr_state_t;
endpackage

/* rtl/pmtr_sio.sv */
// serial data pin split into input, output and enable, clock sampled in
`timescale 1ns/10ps
module pmtr_sio
   import pmtr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic drive_req,
   input wire logic drive_bit,
   output logic ser_data_out,
   output logic ser_data_oe,
   output logic data_q,
   output logic clk_q
);
   logic clk_m;
   logic data_m;

   // two-stage sync; first stage read only by the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         clk_m <= 1'b0;
         clk_q <= 1'b0;
         data_m <= 1'b0;
         data_q <= 1'b0;
      end else begin
         clk_m <= ser_clk_in;
         clk_q <= clk_m;
         data_m <= ser_data_in;
         data_q <= data_m;
      end
   end

   // the far end owns the clock; we only ever drive the data pin
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ser_data_out <= 1'b0;
         ser_data_oe <= 1'b0;
      end else begin
         ser_data_out <= drive_bit;
         ser_data_oe <= drive_req;
      end
   end
endmodule

/* rtl/pmtr_top.sv */
// program memory read port: fetch, table read and serial pin plumbing
`timescale 1ns/10ps
module pmtr_top
   import pmtr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] pc_size_mask,
   input wire logic fetch_advance,
   input wire logic branch_req,
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] branch_addr,
   input wire logic table_req,
   input wire logic extended_table_read_op,
   input wire logic [pmtr_pkg::PMTR_BYTE_W-1:0] table_ptr_low,
   input wire logic [pmtr_pkg::PMTR_BYTE_W-1:0] table_ptr_high,
   input wire logic [pmtr_pkg::PMTR_SECT_W-1:0] dest_sector,
   input wire logic [pmtr_pkg::PMTR_DADDR_W-1:0] dest_addr,
   input wire logic latch_wr,
   input wire logic [pmtr_pkg::PMTR_BYTE_W-1:0] latch_wdata,
   input wire logic prog_wr_en,
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] prog_wr_addr,
   input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] prog_wr_data,
   input wire logic prog_serial_clock,
   input wire logic prog_serial_data_in,
   input wire logic prog_drive_req,
   input wire logic prog_drive_bit,
   input wire logic debug_serial_clock,
   input wire logic debug_serial_data_in,
   input wire logic debug_drive_req,
   input wire logic debug_drive_bit,
   output logic [pmtr_pkg::PMTR_ADDR_W-1:0] pc_q,
   output logic [pmtr_pkg::PMTR_WORD_W-1:0] instr_q,
   output logic instr_valid_q,
   output logic busy_q,
   output logic table_reject_q,
   output logic dest_wr_q,
   output logic [pmtr_pkg::PMTR_SECT_W-1:0] dest_sector_q,
   output logic [pmtr_pkg::PMTR_DADDR_W-1:0] dest_addr_q,
   output logic [pmtr_pkg::PMTR_BYTE_W-1:0] dest_data_q,
   output logic [pmtr_pkg::PMTR_BYTE_W-1:0] table_high_latch,
   output logic prog_serial_data_out,
   output logic prog_serial_data_oe,
   output logic prog_data_q,
   output logic prog_clk_q,
   output logic debug_serial_data_out,
   output logic debug_serial_data_oe,
   output logic debug_data_q,
   output logic debug_clk_q
);
   pmtr_state_t state_q;
   pmtr_state_t state_d;
   logic [PMTR_ADDR_W-1:0] pc_d;
   logic [PMTR_ADDR_W-1:0] mem_addr;
   logic [PMTR_ADDR_W-1:0] table_addr;
   logic [PMTR_ADDR_W-1:0] table_addr_q;
   logic [PMTR_WORD_W-1:0] mem_rdata;
   logic [PMTR_SECT_W-1:0] pend_sector_q;
   logic [PMTR_DADDR_W-1:0] pend_addr_q;
   logic table_ok;
   logic fetch_q;
   logic table_rd_q;
   logic [PMTR_WORD_W-1:0] word_masked;
   logic [2*PMTR_BYTE_W-1:0] ptr_full;

   // full table address from both pointer bytes; low byte offsets the page
   assign ptr_full = {table_ptr_high, table_ptr_low};
   // pointer bits above the deepest variant are cut on purpose
   assign table_addr = ptr_full[PMTR_ADDR_W-1:0];

   // sector 0 only for the basic form, any sector for the extended form
   assign table_ok = table_req &&
      (extended_table_read_op || (dest_sector == PMTR_SECTOR0));

   // unused high word bits of smaller variants are forced low
   assign word_masked = mem_rdata & {{(PMTR_WORD_W-PMTR_ADDR_W){1'b1}}, pc_size_mask};

   // memory port mux: table cycle steals the port from the fetch
   always_comb begin
      if (state_q == PMTR_ST_TABLE) begin
         mem_addr = table_addr_q;
      end else begin
         mem_addr = pc_q & pc_size_mask;
      end
   end

   // sequencer: fetch, table second cycle, flush after a branch
   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      case (state_q)
         PMTR_ST_FETCH: begin
            if (branch_req) begin
               pc_d = branch_addr & pc_size_mask;
               state_d = PMTR_ST_FLUSH;
            end else if (table_ok) begin
               state_d = PMTR_ST_TABLE;
               // the word fetched beside the request is kept, so step past it
               if (fetch_advance) begin
                  pc_d = (pc_q + PMTR_PC_STEP) & pc_size_mask;
               end
            end else if (fetch_advance) begin
               pc_d = (pc_q + PMTR_PC_STEP) & pc_size_mask;
            end
         end
         PMTR_ST_TABLE: begin
            state_d = PMTR_ST_FETCH;
         end
         PMTR_ST_FLUSH: begin
            state_d = PMTR_ST_FETCH;
            // refill slot reads the target, so the counter moves on
            if (fetch_advance) begin
               pc_d = (pc_q + PMTR_PC_STEP) & pc_size_mask;
            end
         end
         default: begin
            state_d = PMTR_ST_FETCH;
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= PMTR_ST_FETCH;
      end else begin
         state_q <= state_d;
      end
   end

   // program counter; reset lands it on the reset entry
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pc_q <= PMTR_RESET_VEC;
      end else begin
         pc_q <= pc_d;
      end
   end

   // capture the table request so the pointers may move afterwards
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         table_addr_q <= PMTR_RESET_VEC;
         pend_sector_q <= PMTR_SECTOR0;
         pend_addr_q <= '0;
      end else if (state_q == PMTR_ST_FETCH && table_ok && !branch_req) begin
         table_addr_q <= table_addr & pc_size_mask;
         pend_sector_q <= dest_sector;
         pend_addr_q <= dest_addr;
      end
   end

   // busy through the table or flush slot; requests then are ignored
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != PMTR_ST_FETCH);
      end
   end

   // one-cycle pulse for a basic read aimed outside sector 0
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         table_reject_q <= 1'b0;
      end else begin
         table_reject_q <= (state_q == PMTR_ST_FETCH) && table_req && !table_ok
            && !branch_req;
      end
   end

   // live fetch slot; the word read beside a taken branch is flushed
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fetch_q <= 1'b0;
      end else begin
         fetch_q <= (state_q == PMTR_ST_FLUSH)
            || ((state_q == PMTR_ST_FETCH) && !branch_req);
      end
   end

   // table word is coming back from the memory next cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         table_rd_q <= 1'b0;
      end else begin
         table_rd_q <= (state_q == PMTR_ST_TABLE);
      end
   end

   // valid pulse; flushed slot and table slot carry no instruction
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         instr_valid_q <= 1'b0;
      end else begin
         instr_valid_q <= fetch_q;
      end
   end

   // instruction word holds until the next live fetch
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         instr_q <= PMTR_WORD_RST;
      end else if (fetch_q) begin
         instr_q <= word_masked;
      end
   end

   // one-cycle write strobe towards the named data register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dest_wr_q <= 1'b0;
      end else begin
         dest_wr_q <= table_rd_q;
      end
   end

   // low byte and its target; held until the next table load
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dest_sector_q <= PMTR_SECTOR0;
         dest_addr_q <= '0;
         dest_data_q <= PMTR_LATCH_RST;
      end else if (table_rd_q) begin
         dest_sector_q <= pend_sector_q;
         dest_addr_q <= pend_addr_q;
         dest_data_q <= word_masked[PMTR_BYTE_W-1:0];
      end
   end

   // table high latch; table load wins over a software write that cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         table_high_latch <= PMTR_LATCH_RST;
      end else if (table_rd_q) begin
         table_high_latch <= word_masked[PMTR_WORD_W-1:PMTR_BYTE_W];
      end else if (latch_wr) begin
         table_high_latch <= latch_wdata;
      end
   end

   pmtr_mem u_mem (
      .sys_clk(sys_clk),
      .rd_addr(mem_addr),
      .rd_data(mem_rdata),
      .wr_en(prog_wr_en),
      .wr_addr(prog_wr_addr),
      .wr_data(prog_wr_data)
   );

   // programming link: two-way data, clock from the programmer
   pmtr_sio u_prog (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ser_clk_in(prog_serial_clock),
      .ser_data_in(prog_serial_data_in),
      .drive_req(prog_drive_req),
      .drive_bit(prog_drive_bit),
      .ser_data_out(prog_serial_data_out),
      .ser_data_oe(prog_serial_data_oe),
      .data_q(prog_data_q),
      .clk_q(prog_clk_q)
   );

   // debug link: clock is input only, data is two-way
   pmtr_sio u_debug (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ser_clk_in(debug_serial_clock),
      .ser_data_in(debug_serial_data_in),
      .drive_req(debug_drive_req),
      .drive_bit(debug_drive_bit),
      .ser_data_out(debug_serial_data_out),
      .ser_data_oe(debug_serial_data_oe),
      .data_q(debug_data_q),
      .clk_q(debug_clk_q)
   );
endmodule

/* tb/pmtr_tool_model.sv */
// external programming or debug tool: clock source and shared data pin
`timescale 1ns/10ps
module pmtr_tool_model #(
   parameter logic PULL = 1'b1
) (
   input wire logic oe,
   input wire logic dout,
   output logic ser_clk,
   output logic pin
);
   logic drv = 1'b0;
   logic bit_v = 1'b0;
   initial ser_clk = 1'b0;
   // device drive first, then the tool, else the pull level
   assign pin = oe ? dout : (drv ? bit_v : PULL);
   // frame opens; called at a clock edge so both lines move together
   task automatic start_bit(input logic b);
      drv <= 1'b1;
      bit_v <= b;
      ser_clk <= 1'b1;
   endtask
   // clock rests low between frames, data line let go
   task automatic stop_bit();
      ser_clk <= 1'b0;
      drv <= 1'b0;
   endtask
endmodule

/* tb/pmtr_top_asserts.sv */
// concurrent checks on the program memory table read port
`timescale 1ns/10ps
module pmtr_top_asserts
   import pmtr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [PMTR_ADDR_W-1:0] pc_size_mask,
   input wire logic [PMTR_ADDR_W-1:0] branch_addr,
   input wire logic [PMTR_ADDR_W-1:0] pc_q,
   input wire logic [PMTR_SECT_W-1:0] dest_sector,
   input wire logic [PMTR_SECT_W-1:0] dest_sector_q,
   input wire logic [PMTR_DADDR_W-1:0] dest_addr,
   input wire logic [PMTR_DADDR_W-1:0] dest_addr_q,
   input wire logic [PMTR_BYTE_W-1:0] latch_wdata,
   input wire logic [PMTR_BYTE_W-1:0] table_high_latch,
   input wire logic table_req,
   input wire logic extended_table_read_op,
   input wire logic branch_req,
   input wire logic latch_wr,
   input wire logic prog_drive_req,
   input wire logic prog_drive_bit,
   input wire logic prog_serial_data_out,
   input wire logic prog_serial_data_oe,
   input wire logic busy_q,
   input wire logic table_reject_q,
   input wire logic dest_wr_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // request the port takes, and whether its form suits the sector
   wire logic take = table_req && !busy_q && !branch_req;
   wire logic ok = extended_table_read_op || dest_sector == PMTR_SECTOR0;
   tbl_latency_a: assert property (take && ok |-> ##3 dest_wr_q)
      else $error("table load late or missing");
   tbl_stall_a: assert property (take && ok |=> busy_q ##1 !busy_q)
      else $error("fetch stall not one cycle");
   basic_reject_a: assert property (take && !ok |=> table_reject_q ##2 !dest_wr_q)
      else $error("basic read outside sector zero not refused");
   dest_target_a: assert property (dest_wr_q |-> dest_sector_q == $past(dest_sector, 3)
      && dest_addr_q == $past(dest_addr, 3)) else $error("low byte to wrong register");
   branch_load_a: assert property (branch_req && !busy_q |=> busy_q
      && pc_q == ($past(branch_addr) & pc_size_mask)) else $error("branch not loaded");
   reset_entry_a: assert property ($fell(sys_rst) |-> pc_q == PMTR_RESET_VEC)
      else $error("counter not at entry after reset");
   latch_source_a: assert property ($changed(table_high_latch) |-> dest_wr_q || $past(latch_wr))
      else $error("latch changed without cause");
   latch_write_a: assert property (latch_wr && pc_size_mask == 14'h3fff ##1 !dest_wr_q
      |-> table_high_latch == $past(latch_wdata)) else $error("latch write lost");
   pin_drive_a: assert property (prog_drive_req |=> prog_serial_data_oe
      && prog_serial_data_out == $past(prog_drive_bit)) else $error("pin not driven");
   cover property (take && ok);
   cover property (take && !ok);
   cover property (branch_req && !busy_q);
endmodule
bind pmtr_top pmtr_top_asserts u_pmtr_top_asserts (.*);

/* tb/tb_top.sv */
// self-checking bench for the program memory table read port
`timescale 1ns/10ps
module tb_top;
   import pmtr_pkg::*;
   logic sys_clk, sys_rst, fetch_advance, branch_req, table_req, extended_table_read_op;
   logic latch_wr, prog_wr_en, prog_drive_req, prog_drive_bit, debug_drive_req;
   logic debug_drive_bit, prog_serial_clock, prog_serial_data_in, debug_serial_clock;
   logic debug_serial_data_in, instr_valid_q, busy_q, table_reject_q, dest_wr_q;
   logic prog_serial_data_out, prog_serial_data_oe, prog_data_q, prog_clk_q;
   logic debug_serial_data_out, debug_serial_data_oe, debug_data_q, debug_clk_q;
   logic [PMTR_ADDR_W-1:0] pc_size_mask, branch_addr, prog_wr_addr, pc_q;
   logic [PMTR_BYTE_W-1:0] table_ptr_low, table_ptr_high, dest_addr, latch_wdata;
   logic [PMTR_BYTE_W-1:0] dest_addr_q, dest_data_q, table_high_latch;
   logic [PMTR_SECT_W-1:0] dest_sector, dest_sector_q;
   logic [PMTR_WORD_W-1:0] prog_wr_data, instr_q;
   int num_errors, n_compared;
   pmtr_top u_pmtr_top (.*);
   pmtr_tool_model #(.PULL(1'b1)) u_prog_tool (.oe(prog_serial_data_oe),
      .dout(prog_serial_data_out), .ser_clk(prog_serial_clock), .pin(prog_serial_data_in));
   pmtr_tool_model #(.PULL(1'b0)) u_dbg_tool (.oe(debug_serial_data_oe),
      .dout(debug_serial_data_out), .ser_clk(debug_serial_clock), .pin(debug_serial_data_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // settle past the edge so registered outputs are stable
   task automatic smp(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask
   task automatic wr_word(input logic [13:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      prog_wr_en <= 1'b1;
      prog_wr_addr <= a;
      prog_wr_data <= d;
      @(posedge sys_clk);
      prog_wr_en <= 1'b0;
   endtask
   // bounded wait; a hang ends the run as a mismatch
   task automatic wait_valid();
      int i;
      for (i = 0; i < 8 && instr_valid_q !== 1'b1; i++) smp(1);
      if (i == 8) begin
         num_errors++;
         $display("unexpected at %0t: no fetch", $time);
         tally_and_finish();
      end
   endtask
   task automatic tread(input logic ext, input logic [1:0] sec, input logic [7:0] exp);
      @(posedge sys_clk);
      table_req <= 1'b1;
      extended_table_read_op <= ext;
      dest_sector <= sec;
      @(posedge sys_clk);
      table_req <= 1'b0;
      #1 chk(table_reject_q, !ext && sec != 2'h0);
      smp(2);
      chk(dest_wr_q, ext || sec == 2'h0);
      if (ext || sec == 2'h0) chk(dest_sector_q, sec);
      chk(table_high_latch, exp);
   endtask
   task automatic t_reset();
      wr_word(14'h0000, 16'hc35a);
      do_reset();
      #1 chk(pc_q, 16'h0000);
      smp(1);
      chk(pc_q, 16'h0001);
      wait_valid();
      chk(instr_q, 16'hc35a);
      $display("reset test done");
   endtask
   // two reads back to back with a request ignored while busy between them
   task automatic t_pair();
      wr_word(14'h0f06, 16'h2b1a);
      wr_word(14'h0f05, 16'h3c0f);
      @(posedge sys_clk);
      table_req <= 1'b1;
      table_ptr_high <= 8'h0f;
      table_ptr_low <= 8'h06;
      @(posedge sys_clk);
      table_ptr_low <= 8'h05;
      #1 chk(busy_q, 1'b1);
      smp(1);
      chk(busy_q, 1'b0);
      @(posedge sys_clk);
      table_req <= 1'b0;
      #1 chk(dest_data_q, 8'h1a);
      chk(table_high_latch, 8'h2b);
      chk(dest_addr_q, 8'h21);
      smp(1);
      chk(dest_wr_q, 1'b0);
      smp(1);
      chk(dest_data_q, 8'h0f);
      chk(table_high_latch, 8'h3c);
      $display("pair test done");
   endtask
   task automatic t_sect();
      @(posedge sys_clk);
      latch_wr <= 1'b1;
      latch_wdata <= 8'h5a;
      @(posedge sys_clk);
      latch_wr <= 1'b0;
      #1 chk(table_high_latch, 8'h5a);
      for (int s = 3; s >= 0; s--) tread(1'b0, 2'(s), s == 0 ? 8'h3c : 8'h5a);
      for (int s = 0; s < 4; s++) tread(1'b1, 2'(s), 8'h3c);
      $display("sector test done");
   endtask
   task automatic t_branch();
      wr_word(14'h0123, 16'h7e81);
      @(posedge sys_clk);
      branch_req <= 1'b1;
      branch_addr <= 14'h0123;
      @(posedge sys_clk);
      branch_req <= 1'b0;
      #1 chk(pc_q, 16'h0123);
      chk(busy_q, 1'b1);
      smp(1);
      chk(instr_valid_q, 1'b0);
      wait_valid();
      chk(instr_q, 16'h7e81);
      // counter holds while the core withholds its advance
      @(posedge sys_clk);
      fetch_advance <= 1'b0;
      smp(3);
      chk(pc_q, 16'h0126);
      @(posedge sys_clk);
      fetch_advance <= 1'b1;
      $display("branch test done");
   endtask
   task automatic t_pins();
      @(posedge sys_clk);
      {prog_drive_req, prog_drive_bit, debug_drive_req, debug_drive_bit} <= 4'b1011;
      smp(4);
      chk(prog_serial_data_oe, 1'b1);
      chk({prog_data_q, debug_data_q}, 2'b01);
      @(posedge sys_clk);
      {prog_drive_req, debug_drive_req} <= 2'b00;
      u_prog_tool.start_bit(1'b0);
      u_dbg_tool.start_bit(1'b1);
      smp(4);
      chk({prog_clk_q, prog_data_q, debug_clk_q, debug_data_q}, 4'b1011);
      @(posedge sys_clk);
      u_prog_tool.stop_bit();
      u_dbg_tool.stop_bit();
      smp(4);
      chk({prog_clk_q, prog_data_q, debug_serial_data_oe, debug_data_q}, 4'b0100);
      $display("pin test done");
   endtask
   // small variant: latch bits beyond the word are cleared
   task automatic t_mask();
      @(posedge sys_clk);
      pc_size_mask <= 14'h07ff;
      do_reset();
      wr_word(14'h0106, 16'hfff0);
      @(posedge sys_clk);
      {table_ptr_high, table_ptr_low} <= 16'h0106;
      tread(1'b1, 2'h2, 8'hff & {2'b11, 6'h07});
      $display("mask test done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      {branch_req, table_req, extended_table_read_op, latch_wr, prog_wr_en} = '0;
      {prog_drive_req, prog_drive_bit, debug_drive_req, debug_drive_bit} = '0;
      {branch_addr, prog_wr_addr, table_ptr_low, table_ptr_high, latch_wdata} = '0;
      {dest_sector, prog_wr_data} = '0;
      sys_rst = 1'b1;
      fetch_advance = 1'b1;
      pc_size_mask = 14'h3fff;
      dest_addr = 8'h21;
      num_errors = 0;
      n_compared = 0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_pair();
      t_sect();
      t_branch();
      t_pins();
      t_mask();
      tally_and_finish();
   end
endmodule
